// ### design/cls_params.svh
// Register offsets, field positions, reset values for the live status bank.
// Included by the bank module only; definitions only.
`ifndef CLS_PARAMS_SVH
`define CLS_PARAMS_SVH

`define CLS_OFS_INPUT 8'h15
`define CLS_OFS_MONITOR 8'h16
`define CLS_OFS_REGCONV 8'h17
`define CLS_OFS_FLAG_INPUT 8'h1A
`define CLS_OFS_FLAG_MONITOR 8'h1B
`define CLS_OFS_FLAG_REGCONV 8'h1C
`define CLS_OFS_IRQ_MASK_INPUT 8'h20
`define CLS_OFS_IRQ_MASK_MONITOR 8'h21
`define CLS_OFS_IRQ_MASK_REGCONV 8'h22
`define CLS_OFS_ADC_MODE 8'h23
`define CLS_STATUS_RESET 8'h00
`define CLS_MASK_RESET 8'hFF
`define CLS_REGCONV_LIVE 8'hD0
`define CLS_BIT_ADC_DONE 7
`define CLS_BIT_REGN_GOOD 7
`define CLS_BIT_CONV_RUN 6
`define CLS_BIT_ERR_HI 4

`endif

// ### design/cls_pkg.sv
// Types shared by the live status bank.
// Assumes cls_params.svh is on the include path.
package cls_pkg;

    // Condition inputs of the input status register, msb first
    typedef struct packed {
        logic input_one_overvoltage;
        logic input_two_overvoltage;
        logic output_present;
        logic input_one_present;
        logic input_two_present;
        logic bus_present;
        logic fet_pair_one_fitted;
        logic fet_pair_two_fitted;
    } cls_input_s;

    // Condition inputs of the monitor status register, msb first
    typedef struct packed {
        logic conversion_done;
        logic soft_start_timeout;
        logic temp_sense_near_limit;
        logic connector_temp_fault;
        logic battery_temp_fault;
        logic die_overtemp_fault;
        logic die_temp_alarm;
        logic watchdog_expired;
    } cls_monitor_s;

    // Regulator and converter conditions
    typedef struct packed {
        logic internal_regulator_good;
        logic converter_running;
        logic bus_error_high;
    } cls_regconv_s;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cls_bus_req_s;

    typedef logic [7:0] cls_byte_t;

endpackage : cls_pkg

// ### design/cls_status_bank.sv
// Live status bank: three read-only status registers, change flags,
// interrupt masks and one level interrupt.
// Assumes condition inputs come from analogue detectors outside the clock
// domain, and a one-cycle-latency register port master.
//
// Function
// - Input status bit 7 is high while input one is overvoltage.
// - Input status bit 6 is high while input two is overvoltage.
// - Bits 5..2 report output, input one, input two, bus presence.
// - Bits 1 and 0 report FET pairs one and two fitted.
// - Monitor bit 7 set once single-shot conversion completes.
// - Conversion-complete bit reads 0 in continuous mode.
// - Monitor bit 6 high during soft-start timeout.
// - Monitor bit 5 high when temperature sense is near fault limit.
// - Bits 4 and 3 report connector and battery temperature faults.
// - Bits 2 and 1 report die over-temperature fault and alarm.
// - Monitor bit 0 high when the watchdog has expired.
// - Offset 17h bit 7 regulator good, bit 6 converter running.
// - Offset 17h bit 4 bus error high; other bits read 0.
// - Status registers read-only, zero after reset, writes ignored.
// - Each status bit change latches a change flag.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "cls_params.svh"

module cls_status_bank
    import cls_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Condition inputs from the analogue side
    input wire cls_input_s input_cond,
    input wire cls_monitor_s monitor_cond,
    input wire cls_regconv_s regconv_cond,
    // Register port
    input wire cls_bus_req_s bus_req,
    output logic [7:0] rdata,
    // Interrupt
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Three-stage input synchronisers

    localparam int NCOND = 19;
    logic [NCOND-1:0] raw;
    logic [NCOND-1:0] sync1_r;
    logic [NCOND-1:0] sync2_r;
    logic [NCOND-1:0] sync3_r;
    logic [NCOND-1:0] live_r;

    assign raw = {input_cond, monitor_cond, regconv_cond};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            live_r <= '0;
        end else begin
            for (int i = 0; i < NCOND; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    live_r[i] <= sync3_r[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Live status assembly

    logic continuous_mode_r;
    cls_byte_t input_stat;
    cls_byte_t monitor_stat;
    cls_byte_t regconv_stat;
    cls_byte_t input_stat_r;
    cls_byte_t monitor_stat_r;
    cls_byte_t regconv_stat_r;

    assign input_stat = live_r[18:11];

    always_comb begin
        monitor_stat = live_r[10:3];
        if (continuous_mode_r) begin
            monitor_stat[`CLS_BIT_ADC_DONE] = 1'b0;
        end
    end

    always_comb begin
        regconv_stat = 8'h00;
        regconv_stat[`CLS_BIT_REGN_GOOD] = live_r[2];
        regconv_stat[`CLS_BIT_CONV_RUN] = live_r[1];
        regconv_stat[`CLS_BIT_ERR_HI] = live_r[0];
    end

    // Status registers follow conditions every cycle, never written by host
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            input_stat_r <= `CLS_STATUS_RESET;
            monitor_stat_r <= `CLS_STATUS_RESET;
            regconv_stat_r <= `CLS_STATUS_RESET;
        end else begin
            input_stat_r <= input_stat;
            monitor_stat_r <= monitor_stat;
            regconv_stat_r <= regconv_stat;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode

    function automatic logic hit(input cls_bus_req_s req, input logic [7:0] ofs);
        hit = req.wr && (req.addr == ofs);
    endfunction : hit

    function automatic cls_byte_t w1c(input cls_byte_t cur, input cls_byte_t set,
                                      input logic clr, input cls_byte_t data);
        w1c = (cur & ~(clr ? data : 8'h00)) | set;
    endfunction : w1c

    cls_byte_t mask_in_r;
    cls_byte_t mask_mon_r;
    cls_byte_t mask_rc_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            continuous_mode_r <= 1'b0;
        end else if (hit(bus_req, `CLS_OFS_ADC_MODE)) begin
            continuous_mode_r <= bus_req.wdata[0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mask_in_r <= `CLS_MASK_RESET;
            mask_mon_r <= `CLS_MASK_RESET;
            mask_rc_r <= `CLS_MASK_RESET;
        end else begin
            if (hit(bus_req, `CLS_OFS_IRQ_MASK_INPUT)) begin
                mask_in_r <= bus_req.wdata;
            end
            if (hit(bus_req, `CLS_OFS_IRQ_MASK_MONITOR)) begin
                mask_mon_r <= bus_req.wdata;
            end
            if (hit(bus_req, `CLS_OFS_IRQ_MASK_REGCONV)) begin
                mask_rc_r <= bus_req.wdata & `CLS_REGCONV_LIVE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Change flags, sticky, write one to clear, set wins

    cls_byte_t flag_in_r;
    cls_byte_t flag_mon_r;
    cls_byte_t flag_rc_r;
    cls_byte_t chg_in;
    cls_byte_t chg_mon;
    cls_byte_t chg_rc;

    assign chg_in = input_stat ^ input_stat_r;
    assign chg_mon = monitor_stat ^ monitor_stat_r;
    assign chg_rc = regconv_stat ^ regconv_stat_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            flag_in_r <= `CLS_STATUS_RESET;
            flag_mon_r <= `CLS_STATUS_RESET;
            flag_rc_r <= `CLS_STATUS_RESET;
        end else begin
            flag_in_r <= w1c(flag_in_r, chg_in,
                             hit(bus_req, `CLS_OFS_FLAG_INPUT),
                             bus_req.wdata);
            flag_mon_r <= w1c(flag_mon_r, chg_mon,
                              hit(bus_req, `CLS_OFS_FLAG_MONITOR),
                              bus_req.wdata);
            flag_rc_r <= w1c(flag_rc_r, chg_rc,
                             hit(bus_req, `CLS_OFS_FLAG_REGCONV),
                             bus_req.wdata);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((flag_in_r & ~mask_in_r) | (flag_mon_r & ~mask_mon_r)
                     | (flag_rc_r & ~mask_rc_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe, no side effects

    cls_byte_t rd_mux;

    always_comb begin
        unique case (bus_req.addr)
            `CLS_OFS_INPUT: rd_mux = input_stat_r;
            `CLS_OFS_MONITOR: rd_mux = monitor_stat_r;
            `CLS_OFS_REGCONV: rd_mux = regconv_stat_r;
            `CLS_OFS_FLAG_INPUT: rd_mux = flag_in_r;
            `CLS_OFS_FLAG_MONITOR: rd_mux = flag_mon_r;
            `CLS_OFS_FLAG_REGCONV: rd_mux = flag_rc_r;
            `CLS_OFS_IRQ_MASK_INPUT: rd_mux = mask_in_r;
            `CLS_OFS_IRQ_MASK_MONITOR: rd_mux = mask_mon_r;
            `CLS_OFS_IRQ_MASK_REGCONV: rd_mux = mask_rc_r;
            `CLS_OFS_ADC_MODE: rd_mux = {7'h00, continuous_mode_r};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (bus_req.rd) begin
            rdata <= rd_mux;
        end else begin
            rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence input_change_s;
        input_stat_r != $past(input_stat_r);
    endsequence

    ovp_one_track_a: assert property (@(posedge ref_clk) disable iff (srst)
        $past(live_r[18]) |-> input_stat_r[7])
        else $error("input one overvoltage bit not tracking");

    ovp_two_track_a: assert property (@(posedge ref_clk) disable iff (srst)
        input_stat_r[6] == $past(live_r[17]))
        else $error("input two overvoltage bit not tracking");

    presence_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
        input_stat_r[5:2] == $past(live_r[16:13]))
        else $error("presence bits wrong");

    fet_pair_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
        input_stat_r[1:0] == $past(live_r[12:11]))
        else $error("fet pair bits wrong");

    adc_cont_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
        $past(continuous_mode_r) |-> !monitor_stat_r[7])
        else $error("conversion bit set in continuous mode");

    adc_done_set_a: assert property (@(posedge ref_clk) disable iff (srst)
        !continuous_mode_r && live_r[10] ##1 !continuous_mode_r
        |-> monitor_stat_r[7])
        else $error("conversion complete not reported");

    monitor_low_bits_a: assert property (@(posedge ref_clk) disable iff (srst)
        monitor_stat_r[6:0] == $past(live_r[9:3]))
        else $error("monitor bits wrong");

    regconv_map_a: assert property (@(posedge ref_clk) disable iff (srst)
        regconv_stat_r == {$past(live_r[2:1]), 1'b0, $past(live_r[0]), 4'h0})
        else $error("regulator status map wrong");

    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (srst)
        regconv_stat_r[5] == 1'b0 && regconv_stat_r[3:0] == 4'h0)
        else $error("reserved bits not zero");

    reset_zero_a: assert property (@(posedge ref_clk)
        $past(srst) |-> input_stat_r == 8'h00 && rdata == 8'h00)
        else $error("status not zero after reset");

    flag_on_change_a: assert property (@(posedge ref_clk) disable iff (srst)
        input_change_s |=> (flag_in_r & $past(input_stat_r ^ $past(input_stat_r)))
        == $past(input_stat_r ^ $past(input_stat_r)))
        else $error("change flag not latched");

    read_no_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
        bus_req.rd && !bus_req.wr && live_r == $past(live_r)
        && $past(live_r) == $past(live_r, 2)
        |=> $stable(input_stat_r))
        else $error("read changed status");

    soft_start_bit_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        monitor_stat_r[6] == $past(live_r[9]))
        else $error("soft start timeout bit wrong");

    temp_near_bit_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        monitor_stat_r[5] == $past(live_r[8]))
        else $error("temperature near limit bit wrong");

    temp_fault_bits_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        monitor_stat_r[4:3] == $past(live_r[7:6]))
        else $error("temperature fault bits wrong");

    die_temp_bits_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        monitor_stat_r[2:1] == $past(live_r[5:4]))
        else $error("die temperature bits wrong");

    watchdog_bit_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        monitor_stat_r[0] == $past(live_r[3]))
        else $error("watchdog bit wrong");

    reg_good_bit_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        regconv_stat_r[7] == $past(live_r[2]))
        else $error("regulator good bit wrong");

    conv_run_bit_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        regconv_stat_r[6] == $past(live_r[1]))
        else $error("converter running bit wrong");

    bus_err_bit_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        regconv_stat_r[4] == $past(live_r[0]))
        else $error("bus error high bit wrong");

    reset_all_zero_a: assert property (
        @(posedge ref_clk)
        $past(srst) |-> monitor_stat_r == 8'h00 && regconv_stat_r == 8'h00)
        else $error("monitor or regulator status not zero after reset");

    input_flag_set_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $past(chg_in) != 8'h00 |-> (flag_in_r & $past(chg_in)) == $past(chg_in))
        else $error("input change flag lost");

    monitor_flag_set_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $past(chg_mon) != 8'h00 |-> (flag_mon_r & $past(chg_mon)) == $past(chg_mon))
        else $error("monitor change flag lost");

    regconv_flag_set_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $past(chg_rc) != 8'h00 |-> (flag_rc_r & $past(chg_rc)) == $past(chg_rc))
        else $error("regulator change flag lost");

    input_read_data_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $past(bus_req.rd) && $past(bus_req.addr) == `CLS_OFS_INPUT
        |-> rdata == $past(input_stat_r))
        else $error("input status read data wrong");

    rdata_idle_zero_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        !$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data not zero without read");

    adc_done_live_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        !$past(continuous_mode_r) |-> monitor_stat_r[7] == $past(live_r[10]))
        else $error("conversion complete bit wrong in single shot");

    irq_on_flag_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (flag_in_r & ~mask_in_r) != 8'h00 |=> irq)
        else $error("unmasked flag without interrupt");

endmodule : cls_status_bank

`default_nettype wire

// ### verif/cls_host_model.sv
// Host side of the register port: one-cycle write and read strobes.
// Assumes read data is registered and stands only in the cycle after rd.
`timescale 1ns/10ps
`default_nettype none

module cls_host_model
    import cls_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Register port
    output var cls_bus_req_s bus_req,
    input wire logic [7:0] rdata
);

    initial bus_req = '0;

    ////////////////////////////////////////////////////////////////////////
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask : read_reg

endmodule : cls_host_model
`default_nettype wire

// ### verif/tb_cls_status_bank.sv
// Testbench for the live status bank: walks every condition bit,
// checks reset values, ignored writes, continuous mode, flags and irq.
// Assumes status follows a condition within 8 clock edges.
`timescale 1ns/10ps
`default_nettype none

module tb_cls_status_bank
    import cls_pkg::*;
;
    logic ref_clk;
    logic srst = 1'b1;
    cls_input_s input_cond = '0;
    cls_monitor_s monitor_cond = '0;
    cls_regconv_s regconv_cond = '0;
    cls_bus_req_s bus_req;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] got;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;

    cls_status_bank dut (.ref_clk(ref_clk), .srst(srst),
        .input_cond(input_cond), .monitor_cond(monitor_cond),
        .regconv_cond(regconv_cond), .bus_req(bus_req), .rdata(rdata),
        .irq(irq));

    cls_host_model host (.ref_clk(ref_clk), .bus_req(bus_req),
        .rdata(rdata));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_byte

    task automatic cmp_bit(input logic g, input logic e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_bit

    task automatic settle();
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    // Walking one through the conditions behind one status register
    task automatic walk(input logic [7:0] a);
        logic [7:0] one;
        logic [7:0] exp;
        for (int i = 0; i < 8; i++) begin
            one = 8'h01 << i;
            exp = one;
            @(posedge ref_clk);
            if (a == 8'h15) begin
                input_cond <= cls_input_s'(one);
            end else if (a == 8'h16) begin
                monitor_cond <= cls_monitor_s'(one);
            end else begin
                regconv_cond <= cls_regconv_s'(one[2:0]);
                exp = {one[2], one[1], 1'b0, one[0], 4'h0};
            end
            settle();
            host.read_reg(a, got);
            cmp_byte(got, exp);
        end
    endtask : walk

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        for (int a = 8'h15; a <= 8'h17; a++) begin
            host.read_reg(8'(a), got);
            cmp_byte(got, 8'h00);
        end
        walk(8'h15);
        walk(8'h16);
        walk(8'h17);
        // Writes to status ignored; repeated reads keep the value
        host.write_reg(8'h15, 8'h7F);
        host.read_reg(8'h15, got);
        cmp_byte(got, 8'h80);
        host.read_reg(8'h15, got);
        cmp_byte(got, 8'h80);
        @(negedge ref_clk);
        cmp_byte(rdata, 8'h00);
        host.read_reg(8'h40, got);
        cmp_byte(got, 8'h00);
        // Continuous mode hides conversion done
        host.write_reg(8'h23, 8'h01);
        settle();
        host.read_reg(8'h16, got);
        cmp_byte(got, 8'h00);
        host.write_reg(8'h23, 8'h00);
        settle();
        host.read_reg(8'h16, got);
        cmp_byte(got, 8'h80);
        // Flags set but masked: no interrupt
        cmp_bit(irq, 1'b0);
        for (int a = 8'h1A; a <= 8'h1C; a++) begin
            host.write_reg(8'(a), 8'hFF);
        end
        host.read_reg(8'h1A, got);
        cmp_byte(got, 8'h00);
        host.write_reg(8'h20, 8'h00);
        @(posedge ref_clk);
        input_cond <= cls_input_s'(8'h00);
        settle();
        host.read_reg(8'h1A, got);
        cmp_byte(got, 8'h80);
        cmp_bit(irq, 1'b1);
        host.write_reg(8'h1A, 8'h80);
        settle();
        cmp_bit(irq, 1'b0);
        host.read_reg(8'h15, got);
        cmp_byte(got, 8'h00);
        complete_run();
    end

endmodule : tb_cls_status_bank
`default_nettype wire
